// file: common/dpmc_cfg.svh
// Timing and field constants for the page-mode DRAM controller
`ifndef DPMC_CFG_SVH
`define DPMC_CFG_SVH
`define DPMC_CLK_MHZ 100
`define DPMC_REF_NS 9600
`define DPMC_REF_CYC ((`DPMC_REF_NS * `DPMC_CLK_MHZ) / 1000)
`define DPMC_RAS_MAX_NS 10000
`define DPMC_BANK_HI 21
`define DPMC_BANK_LO 20
`define DPMC_T_RD 4'h4
`define DPMC_T_WR 4'h3
`define DPMC_T_PW 4'h2
`define DPMC_T_REF 4'h4
`define DPMC_T_PRE 4'h1
`define DPMC_T_COL 4'h2
`define DPMC_T_CAS 4'h3
`define DPMC_T_BURST_END 4'hA
`define DPMC_T_BURST_ACK 4'h7
`define DPMC_CNT_ONE 4'h1
`define DPMC_CNT_ZERO 4'h0
`endif

// file: common/dpmc_pkg.sv
// Types for the page-mode DRAM controller
package dpmc_pkg;
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_REFRESH, ST_READ, ST_BURST,
		ST_WRITE, ST_OPEN_IDLE, ST_PAGE_WRITE, ST_PRECHARGE
	} dpmc_state_t;
	typedef struct packed {
		logic [3:0] ras_n;
		logic [3:0] we_n;
		logic [3:0] cas_n;
		logic col_sel;
	} dpmc_dram_t;
endpackage

// file: rtl/dpmc_ctrl.sv
// Page-mode DRAM controller state machine with refresh timer
`timescale 1ns/1ps
`include "dpmc_cfg.svh"

// Overview of operation
// - Timer requests refresh every 9.6 us
// - Refresh grant stalls timer until refresh done
// - Nine states timed by four-bit counter
// - Reset, one refresh, then idle
// - Select plus read or store starts access
// - Refresh wins; each waits for other's end
// - Refresh is always CAS-before-RAS
// - Idle: outputs off, counter stopped
// - Writes end in open-row idle, RAS held
// - Single read: ack and strobe at four
// - Burst strobes: first at four, then every two
// - Burst ack between second and third strobe
// - Burst holds RAS, pulses CAS four times
// - Store: ack after three cycles
// - Refresh keeps RAS low under 10 us
// - Address bits 21:20 select bank RAS, WE
// - CAS lanes follow byte enables on writes
// - Same-page store in open row: ack at two
// - Other access after open row precharges first
module dpmc_ctrl (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// Processor bus
	input wire logic DRAM_SEL,
	input wire logic RD,
	input wire logic WR,
	input wire logic BURST,
	input wire logic SAME_PAGE_STORE_HINT,
	input wire logic [3:0] BYTE_EN,
	input wire logic [21:20] ADDR_BANK,
	output logic ACK,
	output logic READ_BUFFER_STROBE,
	// DRAM and data path
	output dpmc_pkg::dpmc_dram_t DRAM,
	output logic XCVR_EN,
	output logic XCVR_TO_CPU,
	// Refresh status
	output logic REF_GRANT
);
	// ----------------------------------------------------------------
	// Refresh timer
	// ----------------------------------------------------------------
	localparam logic [10:0] REF_LAST = 11'(`DPMC_REF_CYC - 1);
	logic [10:0] ref_cnt_q;
	logic ref_pend_q;
	logic ref_pulse;
	logic ref_done;
	dpmc_pkg::dpmc_state_t st_q, st_d;
	logic [3:0] cnt_q;

	assign ref_pulse = (ref_cnt_q == REF_LAST) && !ref_pend_q;
	assign ref_done = (st_q == dpmc_pkg::ST_REFRESH) && (cnt_q == `DPMC_T_REF);
	assign REF_GRANT = ref_pend_q;

	// Timer freezes while a grant is outstanding, so requests never stack
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ref_cnt_q <= 11'h000;
		end else if (!ref_pend_q) begin
			ref_cnt_q <= ref_pulse ? 11'h000 : ref_cnt_q + 11'h001;
		end
	end

	// Grant set wins over the clear of the serviced refresh
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ref_pend_q <= 1'b0;
		end else if (ref_pulse) begin
			ref_pend_q <= 1'b1;
		end else if (ref_done) begin
			ref_pend_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State decode
	// ----------------------------------------------------------------
	logic req_any, req_rd, req_wr, req_pw, cnt_run;
	logic [3:0] bank_dec;
	logic [3:0] rd_t;
	assign req_rd = DRAM_SEL && RD;
	assign req_wr = DRAM_SEL && WR;
	assign req_any = req_rd || req_wr;
	assign req_pw = req_wr && SAME_PAGE_STORE_HINT;
	assign cnt_run = (st_q != dpmc_pkg::ST_IDLE)
		&& (st_q != dpmc_pkg::ST_OPEN_IDLE);

	// Bank one-hot from address bits 21:20
	assign bank_dec = 4'h1 << ADDR_BANK;

	// Next state; refresh checked first in every idle state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			dpmc_pkg::ST_RESET: st_d = dpmc_pkg::ST_REFRESH;
			dpmc_pkg::ST_IDLE: begin
				if (ref_pend_q) st_d = dpmc_pkg::ST_REFRESH;
				else if (req_rd && BURST) st_d = dpmc_pkg::ST_BURST;
				else if (req_rd) st_d = dpmc_pkg::ST_READ;
				else if (req_wr) st_d = dpmc_pkg::ST_WRITE;
			end
			dpmc_pkg::ST_REFRESH:
				if (cnt_q == `DPMC_T_REF) st_d = dpmc_pkg::ST_IDLE;
			dpmc_pkg::ST_READ:
				if (cnt_q == `DPMC_T_RD) st_d = dpmc_pkg::ST_IDLE;
			dpmc_pkg::ST_BURST:
				if (cnt_q == `DPMC_T_BURST_END) st_d = dpmc_pkg::ST_IDLE;
			dpmc_pkg::ST_WRITE:
				if (cnt_q == `DPMC_T_WR) st_d = dpmc_pkg::ST_OPEN_IDLE;
			dpmc_pkg::ST_PAGE_WRITE:
				if (cnt_q == `DPMC_T_PW) st_d = dpmc_pkg::ST_OPEN_IDLE;
			dpmc_pkg::ST_OPEN_IDLE: begin
				if (ref_pend_q) st_d = dpmc_pkg::ST_PRECHARGE;
				else if (req_pw) st_d = dpmc_pkg::ST_PAGE_WRITE;
				else if (req_any) st_d = dpmc_pkg::ST_PRECHARGE;
			end
			dpmc_pkg::ST_PRECHARGE:
				if (cnt_q == `DPMC_T_PRE) st_d = dpmc_pkg::ST_IDLE;
			default: st_d = dpmc_pkg::ST_RESET;
		endcase
	end

	// State and timing counter; counter restarts on every state change
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			st_q <= dpmc_pkg::ST_RESET;
			cnt_q <= `DPMC_CNT_ZERO;
		end else begin
			st_q <= st_d;
			cnt_q <= (st_d != st_q || !cnt_run) ? `DPMC_CNT_ONE
				: cnt_q + `DPMC_CNT_ONE;
		end
	end

	// Bank latch: held over open-row idle so the open bank stays selected
	logic [3:0] bank_q;
	always_ff @(posedge CLOCK) begin
		if (RST) bank_q <= 4'h0;
		else if (st_q == dpmc_pkg::ST_IDLE && req_any) bank_q <= bank_dec;
	end

	// ----------------------------------------------------------------
	// Output decode
	// ----------------------------------------------------------------
	logic in_rd, in_wr, in_ref, ras_on, cas_on, burst_stb, wr_cas;
	assign in_rd = (st_q == dpmc_pkg::ST_READ) || (st_q == dpmc_pkg::ST_BURST);
	assign in_wr = (st_q == dpmc_pkg::ST_WRITE)
		|| (st_q == dpmc_pkg::ST_PAGE_WRITE);
	assign in_ref = (st_q == dpmc_pkg::ST_REFRESH);
	// Refresh: CAS from cycle 1, RAS from cycle 2 (CBR)
	assign ras_on = (in_ref && cnt_q >= `DPMC_T_COL) || in_rd
		|| (st_q == dpmc_pkg::ST_WRITE) || (st_q == dpmc_pkg::ST_PAGE_WRITE)
		|| (st_q == dpmc_pkg::ST_OPEN_IDLE);
	// Burst strobes at counts 4,6,8,10
	assign burst_stb = (st_q == dpmc_pkg::ST_BURST) && cnt_q >= `DPMC_T_RD
		&& !cnt_q[0];
	assign wr_cas = ((st_q == dpmc_pkg::ST_WRITE) && cnt_q >= `DPMC_T_COL)
		|| (st_q == dpmc_pkg::ST_PAGE_WRITE);
	// CAS falls two cycles after RAS on reads, one on stores; column is already selected
	assign cas_on = (in_ref && cnt_q <= `DPMC_T_CAS)
		|| ((st_q == dpmc_pkg::ST_READ) && cnt_q >= `DPMC_T_CAS)
		|| ((st_q == dpmc_pkg::ST_BURST) && cnt_q >= `DPMC_T_CAS
		&& cnt_q[0] == 1'b1)
		|| wr_cas;

	// Combinational decode of the DRAM pins; idle drives all strobes high
	always_comb begin
		DRAM.ras_n = in_ref ? (ras_on ? 4'h0 : 4'hF)
			: (ras_on ? ~bank_q : 4'hF);
		DRAM.we_n = in_wr ? ~bank_q : 4'hF;
		DRAM.cas_n = cas_on ? (in_wr ? ~BYTE_EN : 4'h0) : 4'hF;
		// Page write strobes CAS at once, so the column is already selected
		DRAM.col_sel = ((in_rd || st_q == dpmc_pkg::ST_WRITE)
			&& cnt_q >= `DPMC_T_COL)
			|| (st_q == dpmc_pkg::ST_PAGE_WRITE);
	end

	assign READ_BUFFER_STROBE = ((st_q == dpmc_pkg::ST_READ)
		&& cnt_q == `DPMC_T_RD) || burst_stb;
	assign ACK = ((st_q == dpmc_pkg::ST_READ) && cnt_q == `DPMC_T_RD)
		|| ((st_q == dpmc_pkg::ST_BURST) && cnt_q == `DPMC_T_BURST_ACK)
		|| ((st_q == dpmc_pkg::ST_WRITE) && cnt_q == `DPMC_T_WR)
		|| ((st_q == dpmc_pkg::ST_PAGE_WRITE) && cnt_q == `DPMC_T_PW);
	assign XCVR_EN = in_rd || in_wr;
	assign XCVR_TO_CPU = in_rd;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_reset_refresh: assert property (@(posedge CLOCK)
		$fell(RST) |-> ##1 st_q == dpmc_pkg::ST_REFRESH)
		else $error("no refresh after reset");
	a_idle_quiet: assert property (@(posedge CLOCK) disable iff (RST)
		st_q == dpmc_pkg::ST_IDLE |-> DRAM.ras_n == 4'hF && !ACK
		&& !XCVR_EN && DRAM.cas_n == 4'hF)
		else $error("idle outputs active");
	a_timer_stall: assert property (@(posedge CLOCK) disable iff (RST)
		ref_pend_q && $past(ref_pend_q) |-> $stable(ref_cnt_q))
		else $error("timer ran during grant");
	a_read_ack: assert property (@(posedge CLOCK) disable iff (RST)
		st_q == dpmc_pkg::ST_IDLE && !ref_pend_q && req_rd && !BURST
		|-> ##4 ACK && READ_BUFFER_STROBE)
		else $error("single read ack late");
	a_write_ack: assert property (@(posedge CLOCK) disable iff (RST)
		st_q == dpmc_pkg::ST_IDLE && !ref_pend_q && req_wr
		|-> ##3 ACK ##1 st_q == dpmc_pkg::ST_OPEN_IDLE)
		else $error("write ack wrong");
	a_page_ack: assert property (@(posedge CLOCK) disable iff (RST)
		st_q == dpmc_pkg::ST_OPEN_IDLE && !ref_pend_q && req_pw
		|-> ##2 ACK)
		else $error("page write ack wrong");
	a_burst_seq: assert property (@(posedge CLOCK) disable iff (RST)
		st_q == dpmc_pkg::ST_IDLE && !ref_pend_q && req_rd && BURST
		|-> ##4 READ_BUFFER_STROBE ##2 READ_BUFFER_STROBE
		##1 ACK ##1 READ_BUFFER_STROBE ##2 READ_BUFFER_STROBE)
		else $error("burst sequence wrong");
	a_open_ras: assert property (@(posedge CLOCK) disable iff (RST)
		st_q == dpmc_pkg::ST_OPEN_IDLE |-> DRAM.ras_n != 4'hF)
		else $error("row closed in open idle");
	a_precharge: assert property (@(posedge CLOCK) disable iff (RST)
		st_q == dpmc_pkg::ST_OPEN_IDLE && st_d == dpmc_pkg::ST_PRECHARGE
		|-> ##1 DRAM.ras_n == 4'hF)
		else $error("no precharge");
	a_ref_prio: assert property (@(posedge CLOCK) disable iff (RST)
		st_q == dpmc_pkg::ST_IDLE && ref_pend_q
		|-> ##1 st_q == dpmc_pkg::ST_REFRESH)
		else $error("refresh lost priority");
	a_cbr: assert property (@(posedge CLOCK) disable iff (RST)
		$rose(in_ref) |-> DRAM.cas_n == 4'h0 && DRAM.ras_n == 4'hF
		##1 DRAM.ras_n == 4'h0)
		else $error("refresh not CAS before RAS");
	a_col_before_cas: assert property (@(posedge CLOCK) disable iff (RST)
		cas_on && !in_ref |-> DRAM.col_sel)
		else $error("CAS with row address");

	c_burst: cover property (@(posedge CLOCK) st_q == dpmc_pkg::ST_BURST
		&& cnt_q == `DPMC_T_BURST_END);
	c_page: cover property (@(posedge CLOCK) st_q == dpmc_pkg::ST_PAGE_WRITE);
	c_refresh: cover property (@(posedge CLOCK) ref_done);
	c_pre: cover property (@(posedge CLOCK) st_q == dpmc_pkg::ST_PRECHARGE);
endmodule // dpmc_ctrl

// file: sim/dpmc_cpu_model.sv
// Processor bus model: raises one access, holds it to ack, logs the answer
`timescale 1ns/1ps
module dpmc_cpu_model (
	// Command: hint, burst, read, bank, byte enables
	input wire logic clk,
	input wire logic start,
	input wire logic [8:0] cmd,
	// Bus: select, read, store, burst, hint, byte enables, bank
	output logic [10:0] bus,
	input wire logic ack,
	input wire logic strobe,
	input wire dpmc_pkg::dpmc_dram_t dram,
	input wire logic xen,
	input wire logic xcpu,
	// Log: busy, ack cycle, strobe cycles, banks, lanes, directions
	output logic busy,
	output logic [4:0] ack_at,
	output logic [15:0] strb_map,
	output logic [9:0] seen
);
	logic [4:0] cyc_q = 5'h1E;
	logic [1:0] word_q;
	initial bus = 11'h000;
	assign busy = bus[10] || cyc_q != 5'h1E;
	// Requests move at falling edges and stand until ack is sampled
	always @(negedge clk) begin
		if (start && !busy) begin
			// Burst flag with read asks for four words
			bus <= {1'b1, cmd[6], !cmd[6], cmd[7], cmd[8], cmd[3:0],
				cmd[5:4]};
			{cyc_q, ack_at, strb_map, seen, word_q} <= {10'h3FF, 28'h0};
		end else if (bus[10] && ack_at != 5'h1F) begin
			bus <= {5'h00, ~bus[5:2], bus[1:0]}; // Released lanes flip, not hold
		end
	end
	// Log each rising edge of a 31-cycle window from the request
	always @(posedge clk) begin
		if (cyc_q != 5'h1E) begin
			cyc_q <= cyc_q + 5'h01;
			if (ack && ack_at == 5'h1F) ack_at <= cyc_q + 5'h01;
			if (strobe && cyc_q + 5'h01 < 5'h10) strb_map[cyc_q[3:0] + 4'h1] <= 1'b1;
			word_q <= word_q + {1'b0, strobe}; // Word count
			seen <= seen | {~dram.ras_n, ~dram.cas_n, xen & xcpu, xen & !xcpu};
		end
	end
endmodule // dpmc_cpu_model

// file: sim/dram_page_mode_controller_test.sv
// Self-checking bench for the page-mode DRAM controller
`timescale 1ns/1ps
module dram_page_mode_controller_test;
	logic clk = 1'b0, rst = 1'b1, start = 1'b0;
	logic [8:0] cmd = 9'h000;
	logic [10:0] bus;
	logic ack, strobe, xen, xcpu, grant, busy;
	logic [4:0] ack_at;
	logic [15:0] strb_map;
	logic [9:0] seen;
	dpmc_pkg::dpmc_dram_t dram;
	int err_count = 0, checked = 0;
	dpmc_ctrl DUT (.CLOCK(clk), .RST(rst), .DRAM_SEL(bus[10]), .RD(bus[9]),
		.WR(bus[8]), .BURST(bus[7]), .SAME_PAGE_STORE_HINT(bus[6]),
		.BYTE_EN(bus[5:2]), .ADDR_BANK(bus[1:0]), .ACK(ack),
		.READ_BUFFER_STROBE(strobe), .DRAM(dram), .XCVR_EN(xen),
		.XCVR_TO_CPU(xcpu), .REF_GRANT(grant));
	dpmc_cpu_model cpu (.clk(clk), .start(start), .cmd(cmd), .bus(bus),
		.ack(ack), .strobe(strobe), .dram(dram), .xen(xen), .xcpu(xcpu),
		.busy(busy), .ack_at(ack_at), .strb_map(strb_map), .seen(seen));
	initial forever #5 clk = ~clk;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(string what, logic [15:0] got, logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Bounded wait on grant or on the bus model, at falling edges
	task automatic wait_on(bit on_grant, logic lvl, int lim);
		for (int n = 0; (on_grant ? grant : busy) !== lvl; n++) begin
			if (n == lim) begin
				check("wait bound", 16'h1, 16'h0);
				wrap_up();
			end
			@(negedge clk);
		end
	endtask
	// Start right after a refresh so no refresh falls inside the access
	task automatic run_op(bit after_ref, logic [8:0] c);
		if (after_ref) wait_on(1, 1'b1, 2000);
		if (after_ref) wait_on(1, 1'b0, 50);
		cmd <= c;
		start <= 1'b1;
		@(negedge clk);
		start <= 1'b0;
		@(negedge clk);
		wait_on(0, 1'b0, 80);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_boot();
		logic cbr = 1'b0;
		int h, l;
		repeat (12) begin
			@(negedge clk);
			cbr |= dram.cas_n == 4'h0 && dram.ras_n == 4'hF;
		end
		check("boot refresh", cbr, 1'b1);
		check("idle pins", {ack, strobe, xen, dram}, 16'h1FFE);
		wait_on(1, 1'b1, 2000);
		// Eight periods go by before any access is made
		repeat (8) begin
			for (h = 0; grant === 1'b1 && h < 20; h++) @(negedge clk);
			for (l = 0; grant !== 1'b1 && l < 2000; l++) @(negedge clk);
			check("grant held", h > 0 && h < 20, 1'b1);
			check("period", h + l >= 960 && h + l <= 970,
				1'b1);
		end
	endtask
	task automatic t_reads();
		run_op(1, {3'b001, 2'h2, 4'hF});
		check("read ack", ack_at, 5'h04);
		check("read strobe", strb_map, 16'h0010);
		check("read bank dir", {seen[9:6], seen[1:0]},
			6'h12);
		check("read end", dram, 13'h1FFE);
		run_op(1, {3'b011, 2'h1, 4'hF});
		check("burst ack", ack_at, 5'h07);
		check("burst strobes", strb_map, 16'h0550);
		check("burst bank", seen[9:6], 4'h2);
	endtask
	task automatic t_writes();
		run_op(1, {3'b000, 2'h3, 4'h5});
		check("write ack", ack_at, 5'h03);
		check("write pins", seen, 10'h215);
		check("open row", dram.ras_n, 4'h7);
		run_op(0, {3'b100, 2'h3, 4'hA});
		check("page ack", ack_at, 5'h02);
		check("page lanes", seen[5:2], 4'hA);
		run_op(0, {3'b001, 2'h0, 4'hF});
		check("precharge ack", ack_at, 5'h06);
		check("row closed", dram.ras_n, 4'hF);
		// A read raised while a refresh runs is held off
		wait_on(1, 1'b1, 2000);
		run_op(0, {3'b001, 2'h0, 4'hF});
		check("held off", ack_at > 5'h04 && ack_at < 5'h0E,
			1'b1);
	endtask
	// Main sequence: reset held for eight cycles, then the scenarios
	initial begin
		repeat (8) @(negedge clk);
		rst <= 1'b0;
		t_boot();
		t_reads();
		t_writes();
		wrap_up();
	end
endmodule // dram_page_mode_controller_test
